// [gcs_top.sv]
/*
  Twenty clock control blocks, four PLL models and an AHB-Lite register
  slave. Assumes pins are asynchronous to hclk and that every clock is
  modelled as a level sampled at 100 MHz; fabric inputs share hclk.
*/
//
// Summary of operation
// [RULE_01] Five control blocks per edge, twenty networks.
// [RULE_02] Inputs: two pins, two PLL, DP, internal.
// [RULE_03] Dynamic choice only among pins and PLL outputs.
// [RULE_04] One corner dual-purpose pin per corner feeds.
// [RULE_05] Static bits power down unused networks.
// [RULE_06] Fabric enable gates each network at run time.
// [RULE_07] Disabled network delivers no clock edges.
// [RULE_08] Gating leaves PLL counters and lock alone.
// [RULE_09] First divider output enable uses two registers.
// [RULE_10] Enable sampled on falling source clock edge.
// [RULE_11] Fabric: disable, switch, wait, then re-enable.
// [RULE_12] Five dividers, range 1..512, 256 otherwise.
// [RULE_13] Phase step is one eighth VCO period.
// [RULE_14] VCO post-divider halves, report accounts for it.
// [RULE_15] PLL reference only from pin or PLL global.
// [RULE_16] Direct reference from four same-edge pins.
// [RULE_17] Fabric drives two-bit dynamic source select.
// [RULE_18] Each select code maps to one fixed input.
`timescale 1ns/1ps
`include "gcs_regs.svh"

module gcs_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] clk_pin,
  input wire logic [19:0] dual_purpose_clock_pin,
  input wire logic [7:0] corner_dual_purpose_clock_pin,
  input wire logic [19:0] fabric_clk,
  input wire logic [39:0] fabric_sel,
  input wire logic [19:0] fabric_ena,
  output logic [19:0] global_clock_network,
  output logic [3:0] first_output_divider,
  output logic [3:0] pll_locked
);
  import gcs_pkg::*;

  gcs_top_st_t st_r;
  gcs_top_st_t st_nxt;
  logic [19:0] ena_state;
  logic [19:0] net;
  logic [15:0] pin_f;
  logic [19:0] dp_f;
  logic [7:0] cdp_f;
  logic [31:0] rd;
  logic [4:0] idx;
  logic mapped;
  logic [3:0] rsel;
  logic [3:0] phase_at;
  logic ref_clk;
  logic ref_ok;
  logic [9:0] d;
  logic [9:0] c_new;
  logic [4:0] bidx;
  int unsigned ri;

  assign pin_f = st_r.filt[15:0];
  assign dp_f = st_r.filt[35:16];
  assign cdp_f = st_r.filt[43:36];

  ////////////////////////////////////////////////////////////////////////////
  // Four edges of five blocks each; block k on edge e takes pins
  // 4e+2(k%2)+{0,1} and PLL e outputs k and (k+1)%5.
  for (genvar b = 0; b < 20; b++) begin : g_blk // [RULE_01]
    localparam int E = b / 5;
    localparam int K = b % 5;
    localparam int P0 = 4 * E + 2 * (K % 2);
    localparam int K1 = (K + 1) % 5;
    logic dp_src;
    // Only the edge's first block sees a corner pin, and only the one the
    // corner register picks, so the other stays free as plain I/O.
    if (K == 0) begin : g_corner
      assign dp_src = st_r.corner[E] ? cdp_f[2 * E + 1] : cdp_f[2 * E]; // [RULE_04]
    end else begin : g_dp
      assign dp_src = dp_f[b];
    end
    gcs_blk u_blk (
      .hclk(hclk),
      .hresetn(hresetn),
      .src_ded(pin_f[P0 +: 2]), // [RULE_02]
      .src_pll({st_r.out[E][K1], st_r.out[E][K]}),
      .pll_is_first({K1 == 0, K == 0}),
      .src_dp(dp_src),
      .src_int(fabric_clk[b]),
      .src_class(gcs_src_cls_t'(st_r.cls[2 * b +: 2])),
      .dyn_sel(fabric_sel[2 * b +: 2]), // [RULE_17]
      .ena(fabric_ena[b]), // [RULE_06]
      .power_down(st_r.pd[b]), // [RULE_05]
      .net(net[b]),
      .ena_state(ena_state[b])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    rsel = 4'h0;
    phase_at = 4'h0;
    ref_clk = 1'b0;
    ref_ok = 1'b0;
    d = 10'h000;
    c_new = 10'h000;
    bidx = 5'h00;
    ri = 0;

    // Pins pass three flops; a new level counts once stages two and three
    // agree, which rejects a single-sample glitch.
    st_nxt.s1 = {corner_dual_purpose_clock_pin, dual_purpose_clock_pin, clk_pin};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3));

    // Gating lives in the blocks only; nothing here reads an enable.
    for (int p = 0; p < 4; p++) begin // [RULE_08]
      rsel = st_r.pcfg[p][`GCS_CFG_REF_LSB +: 4];
      if (rsel < 4'h4) begin
        ref_clk = pin_f[4 * p + 32'(rsel)]; // [RULE_16]
        ref_ok = 1'b1;
      end else if (rsel < 4'h9) begin
        bidx = 5'(5 * p) + 5'(rsel - 4'h4);
        ref_clk = net[bidx];
        // A global fed by a DP pin or internal logic may not drive a PLL.
        ref_ok = (st_r.cls[2 * bidx +: 2] == 2'(GCS_CLS_DYN)); // [RULE_15]
      end else begin
        ref_clk = 1'b0;
        ref_ok = 1'b0;
      end
      st_nxt.refd[p] = ref_clk;
      if (!ref_ok) begin
        st_nxt.locked[p] = 1'b0;
      end else if (ref_clk && !st_r.refd[p]) begin
        st_nxt.locked[p] = 1'b1;
      end
      if (st_r.locked[p]) begin
        // One hclk tick stands for one eighth of a VCO period; the post
        // divider doubles the period and so the phase step in hclk ticks.
        if (st_r.vph[p] == (st_r.pcfg[p][`GCS_CFG_POSTDIV] ?
            4'(2 * `GCS_VCO_PHASES - 1) : 4'(`GCS_VCO_PHASES - 1))) begin // [RULE_14]
          st_nxt.vph[p] = 4'h0;
        end else begin
          st_nxt.vph[p] = st_r.vph[p] + 4'h1;
        end
        for (int c = 0; c < 5; c++) begin // [RULE_12]
          ri = 32'(5 * p + c);
          phase_at = {1'b0, st_r.div[ri][`GCS_DIV_PHASE_LSB +: 3]}; // [RULE_13]
          if (st_r.pcfg[p][`GCS_CFG_POSTDIV]) begin
            phase_at = {phase_at[2:0], 1'b0};
          end
          if (st_r.vph[p] == phase_at) begin
            d = (st_r.div[ri][8:0] == 9'h000) ? 10'(`GCS_DIV_MAX_50) :
                {1'b0, st_r.div[ri][8:0]};
            if (!st_r.pcfg[p][`GCS_CFG_DUTY50] && d > 10'(`GCS_DIV_MAX_OTHER)) begin
              d = 10'(`GCS_DIV_MAX_OTHER); // [RULE_12]
            end
            c_new = ({1'b0, st_r.cnt[p][c]} >= d - 10'h001) ? 10'h000 :
                    {1'b0, st_r.cnt[p][c]} + 10'h001;
            st_nxt.cnt[p][c] = c_new[8:0];
            st_nxt.out[p][c] = st_r.pcfg[p][`GCS_CFG_DUTY50] ?
                               (c_new < ((d + 10'h001) >> 1)) : (c_new == 10'h000);
          end
        end
      end
    end

    // AHB-Lite: address phase captured on hready, write data lands in the
    // following cycle; read data is prepared at the address phase.
    st_nxt.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      st_nxt.wr_pend = hwrite & mapped;
      st_nxt.wr_idx = idx;
      st_nxt.rdata = hwrite ? 32'h0000_0000 : rd;
    end
    if (st_r.wr_pend) begin
      if (st_r.wr_idx == 5'(`GCS_OFS_PWRDN >> 2)) begin
        st_nxt.pd = hwdata[19:0]; // [RULE_05]
      end else if (st_r.wr_idx == 5'(`GCS_OFS_CLASS_LO >> 2)) begin
        st_nxt.cls[31:0] = hwdata;
      end else if (st_r.wr_idx == 5'(`GCS_OFS_CLASS_HI >> 2)) begin
        st_nxt.cls[39:32] = hwdata[7:0];
      end else if (st_r.wr_idx == 5'(`GCS_OFS_CORNER >> 2)) begin
        st_nxt.corner = hwdata[3:0]; // [RULE_04]
      end else if (st_r.wr_idx >= `GCS_IDX_PLL_CFG0 && st_r.wr_idx < `GCS_IDX_DIV0) begin
        st_nxt.pcfg[st_r.wr_idx - `GCS_IDX_PLL_CFG0] = hwdata[23:0];
      end else if (st_r.wr_idx >= `GCS_IDX_DIV0 && st_r.wr_idx < `GCS_IDX_LOCK) begin
        st_nxt.div[st_r.wr_idx - `GCS_IDX_DIV0] = hwdata[11:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    idx = haddr[6:2];
    mapped = (haddr[31:7] == 25'h0000000) && (haddr[1:0] == 2'h0) &&
             (idx <= `GCS_IDX_VCO_REPORT);
    rd = 32'h0000_0000;
    if (!mapped) begin
      rd = 32'h0000_0000;
    end else if (idx == 5'(`GCS_OFS_PWRDN >> 2)) begin
      rd = {12'h000, st_r.pd};
    end else if (idx == 5'(`GCS_OFS_CLASS_LO >> 2)) begin
      rd = st_r.cls[31:0];
    end else if (idx == 5'(`GCS_OFS_CLASS_HI >> 2)) begin
      rd = {24'h000000, st_r.cls[39:32]};
    end else if (idx == 5'(`GCS_OFS_CORNER >> 2)) begin
      rd = {28'h0000000, st_r.corner};
    end else if (idx < `GCS_IDX_DIV0) begin
      rd = {8'h00, st_r.pcfg[idx - `GCS_IDX_PLL_CFG0]};
    end else if (idx < `GCS_IDX_LOCK) begin
      rd = {20'h00000, st_r.div[idx - `GCS_IDX_DIV0]};
    end else if (idx == `GCS_IDX_LOCK) begin
      rd = {28'h0000000, st_r.locked};
    end else if (idx == `GCS_IDX_ENA_STATE) begin
      rd = {12'h000, ena_state};
    end else begin
      for (int p = 0; p < 4; p++) begin
        rd[2 * p +: 2] = st_r.pcfg[p][`GCS_CFG_POSTDIV] ? 2'h2 : 2'h1; // [RULE_14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.pd <= `GCS_RST_PWRDN;
      st_r.cls <= `GCS_RST_CLASS;
      st_r.corner <= `GCS_RST_CORNER;
      st_r.pcfg <= {4{`GCS_RST_PLL_CFG}};
      st_r.div <= {20{`GCS_RST_DIV}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign global_clock_network = net;
  assign pll_locked = st_r.locked;
  assign first_output_divider = {st_r.out[3][0], st_r.out[2][0], st_r.out[1][0],
                                 st_r.out[0][0]};

endmodule // gcs_top

// [gcs_regs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  global clock select and gate block. Assumes it is included by bare name.
*/
`ifndef GCS_REGS_SVH
`define GCS_REGS_SVH

`define GCS_OFS_PWRDN      8'h00
`define GCS_OFS_CLASS_LO   8'h04
`define GCS_OFS_CLASS_HI   8'h08
`define GCS_OFS_CORNER     8'h0c
`define GCS_OFS_PLL_CFG0   8'h10
`define GCS_OFS_DIV0       8'h20
`define GCS_OFS_LOCK       8'h70
`define GCS_OFS_ENA_STATE  8'h74
`define GCS_OFS_VCO_REPORT 8'h78

`define GCS_IDX_PLL_CFG0   5'd4
`define GCS_IDX_DIV0       5'd8
`define GCS_IDX_LOCK       5'd28
`define GCS_IDX_ENA_STATE  5'd29
`define GCS_IDX_VCO_REPORT 5'd30

`define GCS_CFG_N_LSB      0
`define GCS_CFG_M_LSB      9
`define GCS_CFG_POSTDIV    18
`define GCS_CFG_DUTY50     19
`define GCS_CFG_REF_LSB    20
`define GCS_DIV_PHASE_LSB  9

`define GCS_RST_PWRDN      20'h00000
`define GCS_RST_CLASS      40'h00_0000_0000
`define GCS_RST_CORNER     4'h0
`define GCS_RST_PLL_CFG    24'h080201
`define GCS_RST_DIV        12'h002

`define GCS_VCO_PHASES     8
`define GCS_DIV_MAX_50     512
`define GCS_DIV_MAX_OTHER  256

`endif

// [gcs_pkg.sv]
/*
  Types of the global clock select and gate block.
  Assumes nothing of its surroundings.
*/
package gcs_pkg;

  typedef enum logic [1:0] {
    GCS_CLS_DYN = 2'h0,
    GCS_CLS_DP  = 2'h1,
    GCS_CLS_INT = 2'h3
  } gcs_src_cls_t;

  typedef struct packed {
    logic src_d;
    logic ena1;
    logic ena2;
    logic net;
  } gcs_blk_st_t;

  typedef struct packed {
    logic [43:0] s1;
    logic [43:0] s2;
    logic [43:0] s3;
    logic [43:0] filt;
    logic [19:0] pd;
    logic [39:0] cls;
    logic [3:0] corner;
    logic [3:0][23:0] pcfg;
    logic [19:0][11:0] div;
    logic [3:0][3:0] vph;
    logic [3:0][4:0][8:0] cnt;
    logic [3:0][4:0] out;
    logic [3:0] locked;
    logic [3:0] refd;
    logic wr_pend;
    logic [4:0] wr_idx;
    logic [31:0] rdata;
  } gcs_top_st_t;

endpackage

// [gcs_blk.sv]
/*
  One clock control block: source multiplexer and network gate.
  Assumes all source inputs are already in the hclk domain.
*/
`timescale 1ns/1ps

module gcs_blk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] src_ded,
  input wire logic [1:0] src_pll,
  input wire logic [1:0] pll_is_first,
  input wire logic src_dp,
  input wire logic src_int,
  input wire gcs_pkg::gcs_src_cls_t src_class,
  input wire logic [1:0] dyn_sel,
  input wire logic ena,
  input wire logic power_down,
  output logic net,
  output logic ena_state
);
  import gcs_pkg::*;

  gcs_blk_st_t st_r;
  gcs_blk_st_t st_nxt;
  logic cur;
  logic two_stage;
  logic eff;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cur = 1'b0;
    two_stage = 1'b0;
    unique case (src_class)
      GCS_CLS_DYN: begin
        unique case (dyn_sel) // [RULE_03]
          2'h0: cur = src_ded[0]; // [RULE_18]
          2'h1: cur = src_ded[1]; // [RULE_18]
          2'h2: begin
            cur = src_pll[0]; // [RULE_18]
            two_stage = pll_is_first[0]; // [RULE_09]
          end
          2'h3: begin
            cur = src_pll[1]; // [RULE_18]
            two_stage = pll_is_first[1]; // [RULE_09]
          end
        endcase
      end
      GCS_CLS_DP: cur = src_dp; // [RULE_02]
      GCS_CLS_INT: cur = src_int; // [RULE_02]
      default: cur = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // The enable moves only on a falling source edge, so the gate never
  // chops a high phase and the network sees no runt pulse.
  always_comb begin
    st_nxt = st_r;
    st_nxt.src_d = cur;
    if (st_r.src_d && !cur) begin
      st_nxt.ena1 = ena; // [RULE_10]
      st_nxt.ena2 = st_r.ena1; // [RULE_09]
    end
    eff = two_stage ? st_r.ena2 : st_r.ena1; // [RULE_09]
    st_nxt.net = cur & eff & ~power_down; // [RULE_07]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign net = st_r.net;
  assign ena_state = eff & ~power_down;

endmodule // gcs_blk

// [gcs_top_props.sv]
/* Port checker of gcs_top, attached by the bind at the foot.
   Assumes one clock domain, hclk, with hresetn as its reset. */
`timescale 1ns/1ps
module gcs_top_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [15:0] clk_pin,
  input wire logic [39:0] fabric_sel,
  input wire logic [19:0] fabric_ena,
  input wire logic [19:0] global_clock_network,
  input wire logic [3:0] pll_locked
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [4:0] st_r;
  logic [3:0] hi_r;
  logic [3:0] qt_r;
  logic [1:0] sel_r;
  logic pdw_r;
  logic [19:0] pd_r;
  logic wr_ap;
  logic src1;
  logic steady;
  assign wr_ap = hsel && htrans[1] && hready && hwrite;
  assign src1 = fabric_sel[2] ? clk_pin[3] : clk_pin[2];
  assign steady = st_r == 5'h1f;
  // Counters only track inputs; the sync depth of the pins is covered by the delay ranges.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= 5'h0;
      hi_r <= 4'h0;
      qt_r <= 4'h0;
      sel_r <= 2'h0;
      pdw_r <= 1'b0;
      pd_r <= 20'h0;
    end else begin
      sel_r <= fabric_sel[3:2];
      st_r <= (fabric_ena[1] && !fabric_sel[3] && fabric_sel[3:2] == sel_r) ?
        st_r + {4'h0, !steady} : 5'h0;
      hi_r <= (src1 && fabric_sel[3:2] == sel_r) ? hi_r + {3'h0, hi_r != 4'hf} : 4'h0;
      qt_r <= wr_ap ? 4'h0 : qt_r + {3'h0, qt_r != 4'hf};
      pdw_r <= wr_ap && haddr == 32'h0;
      if (pdw_r) pd_r <= hwdata[19:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_pin_rise;
    steady && $rose(src1) |-> ##[3:6] global_clock_network[1];
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("network missed pin rise");
  property p_pin_fall;
    steady && $fell(src1) |-> ##[3:6] !global_clock_network[1];
  endproperty
  a_pin_fall: assert property (p_pin_fall) else $error("network missed pin fall");
  property p_no_early;
    !fabric_sel[3] && hi_r >= 4'h8 |-> !$rose(global_clock_network[1]);
  endproperty
  a_no_early: assert property (p_no_early) else $error("enable acted while high");
  property p_gate_off1;
    $fell(fabric_ena[1]) && global_clock_network[1] |=>
      !$rose(global_clock_network[1]) until fabric_ena[1];
  endproperty
  a_gate_off1: assert property (p_gate_off1) else $error("gated network 1 ticked");
  property p_gate_off2;
    $fell(fabric_ena[2]) && global_clock_network[2] |=>
      !$rose(global_clock_network[2]) until fabric_ena[2];
  endproperty
  a_gate_off2: assert property (p_gate_off2) else $error("gated network 2 ticked");
  property p_two_stage;
    $fell(fabric_ena[0]) && global_clock_network[0] && fabric_sel[1:0] == 2'h2 |->
      ##[1:40] $rose(global_clock_network[0]);
  endproperty
  a_two_stage: assert property (p_two_stage) else $error("no late pulse on block 0");
  property p_lock;
    pll_locked[0] && qt_r >= 4'h6 |=> pll_locked[0];
  endproperty
  a_lock: assert property (p_lock) else $error("lock lost without write");
  property p_pwrdn;
    (pd_r & $past(pd_r, 2) & global_clock_network) == 20'h0;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("powered down network active");
  c_two: cover property ($fell(fabric_ena[0]) && global_clock_network[0]);
  c_pin: cover property (steady && $rose(src1));
  c_pd: cover property (pd_r[3] && $past(pd_r[3], 2));
endmodule // gcs_top_props
bind gcs_top gcs_top_props u_props (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .clk_pin(clk_pin),
  .fabric_sel(fabric_sel),
  .fabric_ena(fabric_ena),
  .global_clock_network(global_clock_network),
  .pll_locked(pll_locked)
);

// [gcs_fabric_model.sv]
/* Fabric user logic: dynamic selects, gate enables, internal clocks.
   Assumes one request at a time, made while busy is low. */
`timescale 1ns/1ps
module gcs_fabric_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic off,
  input wire logic [4:0] blk,
  input wire logic [1:0] nsel,
  output logic [39:0] fabric_sel,
  output logic [19:0] fabric_ena,
  output logic [19:0] fabric_clk,
  output logic busy
);
  logic [5:0] wt_r;
  logic [4:0] b_r;
  logic [1:0] s_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fabric_sel <= 40'h0;
      fabric_ena <= 20'hfffff;
      fabric_clk <= 20'h0;
      busy <= 1'b0;
      wt_r <= 6'h0;
      b_r <= 5'h0;
      s_r <= 2'h0;
    end else begin
      fabric_clk <= fabric_clk + 20'h1;
      if (go) begin
        fabric_ena[blk] <= 1'b0;
        b_r <= blk;
        s_r <= nsel;
        busy <= !off;
        wt_r <= 6'h1;
      end else if (busy) begin
        wt_r <= wt_r + 6'h1;
        if (wt_r == 6'h4) fabric_sel[2*b_r +: 2] <= s_r;
        // A long settle keeps the new source clean before the gate opens.
        if (wt_r == 6'h28) begin
          fabric_ena[b_r] <= 1'b1;
          busy <= 1'b0;
        end
      end
    end
  end
endmodule // gcs_fabric_model

// [gcs_top_tb_top.sv]
/* Testbench of gcs_top: AHB-Lite register tasks and clock counting.
   Assumes the fabric model and the checker are compiled alongside. */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %0h exp %0h", $time, (a), (e)); end end
module gcs_top_tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, go, off, busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, nsel;
  logic [15:0] clk_pin;
  logic [39:0] fabric_sel;
  logic [19:0] fabric_ena, fabric_clk, net;
  logic [3:0] locked;
  logic [4:0] blk;
  int n_errors = 0, checks = 0, pc, c, i;
  int ex[4] = '{20, 12, 15, 15};
  gcs_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clk_pin(clk_pin),
    .dual_purpose_clock_pin(20'h0), .corner_dual_purpose_clock_pin(8'h0),
    .fabric_clk(fabric_clk), .fabric_sel(fabric_sel), .fabric_ena(fabric_ena),
    .global_clock_network(net), .first_output_divider(), .pll_locked(locked));
  gcs_fabric_model u_fab (.hclk(hclk), .hresetn(hresetn), .go(go), .off(off), .blk(blk),
    .nsel(nsel), .fabric_sel(fabric_sel), .fabric_ena(fabric_ena),
    .fabric_clk(fabric_clk), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    pc <= pc + 1;
    clk_pin <= {8{(pc % 20) < 10, (pc % 12) < 6}};
  end
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    ahb(1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, e);
    logic [31:0] r;
    ahb(0, a, 32'h0, r);
    `CHK(r, e)
  endtask
  task automatic fab(input logic [4:0] b, input logic [1:0] s, input logic o);
    @(posedge hclk);
    go <= 1;
    blk <= b;
    nsel <= s;
    off <= o;
    @(posedge hclk);
    go <= 0;
    @(posedge hclk);
    for (int k = 0; k < 200 && busy; k++) @(posedge hclk);
  endtask
  // Counts rising edges over n cycles after a settle of s cycles.
  task automatic rises(input int b, s, n, output int cnt);
    logic p;
    repeat (s) @(negedge hclk);
    cnt = 0;
    p = net[b];
    repeat (n) begin
      @(negedge hclk);
      if (net[b] && !p) cnt++;
      p = net[b];
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    {hresetn, hsel, hwrite, go, off, haddr, htrans, hwdata, blk, nsel, clk_pin, pc} = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    repeat (60) @(posedge hclk);
    rd(32'h00, 32'h0);
    rd(32'h04, 32'h0);
    rd(32'h10, 32'h080201);
    rd(32'h20, 32'h2);
    rd(32'h78, 32'h55);
    rd(32'h70, 32'hf);
    wr(32'h70, 32'h0);
    rd(32'h70, 32'hf);
    rd(32'h7c, 32'h0);
    wr(32'h1c, 32'h9c4201);
    rd(32'h70, 32'h7);
    wr(32'h1c, 32'h0c4201);
    rd(32'h1c, 32'h0c4201);
    rd(32'h78, 32'h95);
    wr(32'h04, 32'hc0);
    rises(3, 32, 240, c);
    `CHK(c, 15)
    wr(32'h00, 32'h8);
    rises(3, 32, 240, c);
    `CHK(c, 0)
    wr(32'h00, 32'h0);
    for (int s = 0; s < 4; s++) begin
      fab(5'd1, s[1:0], 1'b0);
      rises(1, 32, 240, c);
      `CHK(c, ex[s])
    end
    for (int b = 0; b < 3; b += 2) begin
      fab(b[4:0], 2'h2, 1'b0);
      for (i = 0; i < 64 && net[b] !== 1'b0; i++) @(negedge hclk);
      for (i = 0; i < 64 && net[b] !== 1'b1; i++) @(negedge hclk);
      fab(b[4:0], 2'h2, 1'b1);
      rises(b, 0, 100, c);
      `CHK(c, b == 0 ? 1 : 0)
    end
    `CHK(locked, 4'hf)
    rd(32'h70, 32'hf);
    tally_and_finish;
  end
endmodule // gcs_top_tb_top
